// File: rtl/pofs_sequencer.sv
// Overcurrent, hiccup, fault and thermal switching sequencer.
// Contract
// RULE1: Sense above limit enters cycle-by-cycle limiting.
// RULE2: Limiting: on each cycle, off at limit.
// RULE3: Limit hit pulses hiccup charge until cycle end.
// RULE4: Keep limiting until hiccup timer reaches delay.
// RULE5: At delay threshold discharge soft-start, stop switching.
// RULE6: Then pull timer to top, slowly discharge.
// RULE7: No switching until restart threshold, then soft-start.
// RULE8: Resume normally, or repeat limiting and hiccup.
// RULE9: Fault only after input held qualification width.
// RULE10: Qualified fault: discharge soft-start, outputs low.
// RULE11: On release wait fifteen cycles plus logic delay.
// RULE12: After post-fault wait restart soft-start.
// RULE13: Fault during wait restarts whole fault sequence.
// RULE14: Over-temperature stops switching until release level.
// RULE15: Normal: on each cycle, off at scaled error level.
// RULE16: Flags synchronised; each protection forces outputs low.
module pofs_sequencer #(
    parameter int QUAL_CYC  = pofs_pkg::FLT_QUAL_CYC,
    parameter int SW_CYC    = pofs_pkg::FLT_DELAY_SW_CYC,
    parameter int LOGIC_CYC = pofs_pkg::FLT_LOGIC_DLY_CYC
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    // Switching clock cycle start, one-cycle pulse from oscillator logic
    input  wire logic i_cycle_start,
    // Comparator flags from the analog front end (asynchronous)
    input  wire logic i_current_sense_input_lim,
    input  wire logic i_comp_to_sense_ratio_trip,
    input  wire logic i_restart_timer_node_delay_reached,
    input  wire logic i_restart_timer_node_top_reached,
    input  wire logic i_restart_timer_node_restart_reached,
    input  wire logic i_fault_rise,
    input  wire logic i_fault_above_fall,
    input  wire logic i_thermal_hot,
    input  wire logic i_thermal_above_release,
    // Drive and analog control outputs
    output logic      o_primary_drive_a,
    output logic      o_primary_drive_b,
    output logic      o_restart_timer_charge,
    output logic      o_restart_timer_pullup,
    output logic      o_restart_timer_discharge,
    output logic      o_soft_start_discharge,
    output logic      o_soft_start_begin,
    output logic      o_limiting
);
    localparam int NF = 9;
    logic [NF-1:0] flags_s;
    logic          cs_lim;
    logic          pwm_trip;
    logic          hd_delay;
    logic          hd_top;
    logic          hd_restart;
    logic          f_rise;
    logic          f_above;
    logic          t_hot;
    logic          t_above;

    // Every analog crossing is resynchronised before use. [RULE16]
    pofs_sync #(.W(NF)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_async   ({i_current_sense_input_lim, i_comp_to_sense_ratio_trip,
                     i_restart_timer_node_delay_reached, i_restart_timer_node_top_reached,
                     i_restart_timer_node_restart_reached, i_fault_rise,
                     i_fault_above_fall, i_thermal_hot,
                     i_thermal_above_release}),
        .o_sync    (flags_s)
    );
    assign {cs_lim, pwm_trip, hd_delay, hd_top, hd_restart,
            f_rise, f_above, t_hot, t_above} = flags_s;

    pofs_pkg::pofs_state_e state_r;
    pofs_pkg::pofs_state_e state_nxt;
    logic [pofs_pkg::CNT_W-1:0] qual_r;
    logic [pofs_pkg::CNT_W-1:0] qual_nxt;
    logic [pofs_pkg::CNT_W-1:0] wait_r;
    logic [pofs_pkg::CNT_W-1:0] wait_nxt;
    logic [pofs_pkg::CNT_W-1:0] logic_r;
    logic [pofs_pkg::CNT_W-1:0] logic_nxt;
    logic on_r;
    logic on_nxt;
    logic phase_r;
    logic charge_r;
    logic charge_nxt;
    logic lim_r;
    logic ss_begin_r;
    logic ss_begin_nxt;

    localparam logic [pofs_pkg::CNT_W-1:0] QUAL_LAST =
        pofs_pkg::CNT_W'(QUAL_CYC - 1);
    localparam logic [pofs_pkg::CNT_W-1:0] SW_LAST =
        pofs_pkg::CNT_W'(SW_CYC - 1);
    localparam logic [pofs_pkg::CNT_W-1:0] LOGIC_LAST =
        pofs_pkg::CNT_W'(LOGIC_CYC - 1);

    wire fault_qual  = f_rise && (qual_r == QUAL_LAST);   // [RULE9]
    wire run_state   = (state_r == pofs_pkg::POFS_RUN);
    wire stop_pulse  = pwm_trip || cs_lim;                // [RULE2] [RULE15]
    wire limit_hit   = run_state && on_r && cs_lim;       // [RULE1]

    // Qualification counter restarts whenever the input dips.
    assign qual_nxt = !f_rise ? '0 :
                      (qual_r == QUAL_LAST) ? qual_r :
                      qual_r + 1'b1;                      // [RULE9]

    always_comb
    begin
        state_nxt    = state_r;
        wait_nxt     = wait_r;
        logic_nxt    = logic_r;
        ss_begin_nxt = 1'b0;
        // Thermal and fault take priority over hiccup at every state.
        if (t_hot)
        begin
            state_nxt = pofs_pkg::POFS_THERMAL;           // [RULE14]
        end
        else if (fault_qual && state_r != pofs_pkg::POFS_THERMAL)
        begin
            state_nxt = pofs_pkg::POFS_FAULT;             // [RULE10] [RULE13]
        end
        else
        begin
            case (state_r)
                pofs_pkg::POFS_RUN:
                begin
                    if (hd_delay)
                    begin
                        state_nxt = pofs_pkg::POFS_RESTART_TIMER_NODE_UP; // [RULE4] [RULE5]
                    end
                end
                pofs_pkg::POFS_RESTART_TIMER_NODE_UP:
                begin
                    if (hd_top)
                    begin
                        state_nxt = pofs_pkg::POFS_RESTART_TIMER_NODE_DOWN; // [RULE6]
                    end
                end
                pofs_pkg::POFS_RESTART_TIMER_NODE_DOWN:
                begin
                    if (hd_restart)
                    begin
                        state_nxt    = pofs_pkg::POFS_RUN; // [RULE7] [RULE8]
                        ss_begin_nxt = 1'b1;
                    end
                end
                pofs_pkg::POFS_FAULT:
                begin
                    wait_nxt  = '0;
                    logic_nxt = '0;
                    if (!f_above)
                    begin
                        state_nxt = pofs_pkg::POFS_FAULT_WAIT; // [RULE11]
                    end
                end
                pofs_pkg::POFS_FAULT_WAIT:
                begin
                    if (wait_r != SW_LAST + 1'b1)
                    begin
                        if (i_cycle_start)
                        begin
                            wait_nxt = wait_r + 1'b1;     // [RULE11]
                        end
                    end
                    else if (logic_r != LOGIC_LAST)
                    begin
                        logic_nxt = logic_r + 1'b1;
                    end
                    else
                    begin
                        state_nxt    = pofs_pkg::POFS_RUN; // [RULE12]
                        ss_begin_nxt = 1'b1;
                    end
                end
                default:
                begin
                    if (!t_above)
                    begin
                        state_nxt    = pofs_pkg::POFS_RUN; // [RULE14]
                        ss_begin_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    // Drive turns on at each cycle start, off at either comparator trip.
    always_comb
    begin
        if (!run_state || state_nxt != pofs_pkg::POFS_RUN)
        begin
            on_nxt = 1'b0;                                // [RULE16]
        end
        else if (i_cycle_start)
        begin
            on_nxt = 1'b1;                                // [RULE2] [RULE15]
        end
        else if (stop_pulse)
        begin
            on_nxt = 1'b0;
        end
        else
        begin
            on_nxt = on_r;
        end
    end

    // Charge pulse holds from limit hit until the cycle ends. [RULE3]
    assign charge_nxt = run_state && !i_cycle_start && (limit_hit || charge_r);

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r    <= pofs_pkg::POFS_RUN;
            qual_r     <= '0;
            wait_r     <= '0;
            logic_r    <= '0;
            on_r       <= 1'b0;
            phase_r    <= 1'b0;
            charge_r   <= 1'b0;
            lim_r      <= 1'b0;
            ss_begin_r <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            qual_r     <= qual_nxt;
            wait_r     <= wait_nxt;
            logic_r    <= logic_nxt;
            on_r       <= on_nxt;
            phase_r    <= i_cycle_start ? ~phase_r : phase_r;
            charge_r   <= charge_nxt;
            lim_r      <= run_state && (limit_hit || (lim_r && !hd_delay));
            ss_begin_r <= ss_begin_nxt;
        end
    end

    // Two primary outputs alternate cycles for push-pull use.
    assign o_primary_drive_a         = on_r && !phase_r;
    assign o_primary_drive_b         = on_r && phase_r;
    assign o_restart_timer_charge    = charge_r;
    assign o_restart_timer_pullup    = (state_r == pofs_pkg::POFS_RESTART_TIMER_NODE_UP);
    assign o_restart_timer_discharge = (state_r == pofs_pkg::POFS_RESTART_TIMER_NODE_DOWN);
    assign o_soft_start_discharge    = !run_state;        // [RULE5] [RULE10]
    assign o_soft_start_begin        = ss_begin_r;
    assign o_limiting                = lim_r;

    property p_no_drive_when_stopped;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        !run_state |-> !(o_primary_drive_a || o_primary_drive_b);
    endproperty
    a_no_drive_when_stopped: // [RULE16]
        assert property (p_no_drive_when_stopped)
        else $error("Drive active while stopped.");

    property p_restart_timer_node_entry;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (run_state && hd_delay && !t_hot && !fault_qual)
        |=> (state_r == pofs_pkg::POFS_RESTART_TIMER_NODE_UP) && o_soft_start_discharge;
    endproperty
    a_restart_timer_node_entry: assert property (p_restart_timer_node_entry) // [RULE5]
        else $error("Hiccup not entered at delay threshold.");

    property p_charge_ends;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_cycle_start |=> !o_restart_timer_charge;
    endproperty
    a_charge_ends: assert property (p_charge_ends) // [RULE3]
        else $error("Charge pulse outlived its cycle.");

    property p_charge_on_hit;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (limit_hit && !i_cycle_start) |=> o_restart_timer_charge;
    endproperty
    a_charge_on_hit: assert property (p_charge_on_hit) // [RULE3]
        else $error("Charge pulse missing after limit hit.");

    property p_turn_off_at_limit;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (cs_lim && !i_cycle_start)
        |=> !o_primary_drive_a && !o_primary_drive_b;
    endproperty
    a_turn_off_at_limit: assert property (p_turn_off_at_limit) // [RULE2]
        else $error("Drive stayed on at current limit.");

    // The input must have stood high at both ends of the qualification span.
    property p_fault_qualify;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        $rose(state_r == pofs_pkg::POFS_FAULT)
        |-> $past(f_rise) && $past(f_rise, QUAL_CYC);
    endproperty
    a_fault_qualify: assert property (p_fault_qualify) // [RULE9]
        else $error("Fault without qualified input.");

    property p_restart_timer_node_hold;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (state_r == pofs_pkg::POFS_RESTART_TIMER_NODE_DOWN && !hd_restart && !t_hot
            && !fault_qual) |=> !run_state;
    endproperty
    a_restart_timer_node_hold: assert property (p_restart_timer_node_hold) // [RULE7]
        else $error("Restarted before restart threshold.");

    property p_thermal_stop;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        t_hot |=> (state_r == pofs_pkg::POFS_THERMAL) ##1 !o_primary_drive_a;
    endproperty
    a_thermal_stop: assert property (p_thermal_stop) // [RULE14]
        else $error("Thermal shutdown not taken.");
endmodule

// File: common/pofs_pkg.sv
// Shared constants for the overcurrent and fault switching sequencer.
package pofs_pkg;
    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 50;
    // Least qualification width for the protection input, in nanoseconds.
    localparam int FLT_QUAL_MIN_NS = 400;
    // Longest qualification width, in nanoseconds.
    localparam int FLT_QUAL_MAX_NS = 1400;
    // Qualification count: least time rounded up, at least one cycle.
    localparam int FLT_QUAL_CYC_RAW =
        (FLT_QUAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_QUAL_CYC =
        (FLT_QUAL_CYC_RAW < 1) ? 1 : FLT_QUAL_CYC_RAW;
    // Post-fault wait in switching-clock cycles.
    localparam int FLT_DELAY_SW_CYC = 15;
    // Fixed internal logic delay in nanoseconds after the switching cycles.
    localparam int FLT_LOGIC_DLY_NS = 2000;
    localparam int FLT_LOGIC_DLY_CYC_RAW = FLT_LOGIC_DLY_NS / CLK_PERIOD_NS;
    localparam int FLT_LOGIC_DLY_CYC =
        (FLT_LOGIC_DLY_CYC_RAW < 1) ? 1 : FLT_LOGIC_DLY_CYC_RAW;
    localparam int CNT_W = 8;

    // Sequencer states.
    typedef enum logic [2:0]
    {
        POFS_RUN,
        POFS_RESTART_TIMER_NODE_UP,
        POFS_RESTART_TIMER_NODE_DOWN,
        POFS_FAULT,
        POFS_FAULT_WAIT,
        POFS_THERMAL
    } pofs_state_e;
endpackage

// File: rtl/pofs_sync.sv
// Two flip-flop synchroniser for a bundle of comparator flags.
module pofs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_arst_n,
    // Flags
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// File: test/pofs_stage_model.sv
// Behavioural power stage: sensed current ramp and restart timer node.
module pofs_stage_model (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    // From the sequencer
    input  wire logic i_drive_on,
    input  wire logic i_charge,
    input  wire logic i_pullup,
    input  wire logic i_discharge,
    // Bench control: load above the current limit
    input  wire logic i_overload,
    // Comparator flags
    output logic      o_lim,
    output logic      o_trip,
    output logic      o_delay,
    output logic      o_top,
    output logic      o_restart
);
    timeunit 1ns;
    timeprecision 1ns;
    int cur_r;
    int lvl_r;
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cur_r <= 0;
            lvl_r <= 0;
        end
        else
        begin
            cur_r <= i_drive_on ? cur_r + 1 : 0;
            if (i_pullup)
                lvl_r <= (lvl_r > 80) ? 100 : lvl_r + 20;
            else if (i_discharge && lvl_r > 0)
                lvl_r <= lvl_r - 2;
            else if (i_charge)
                lvl_r <= lvl_r + 2;
        end
    end
    // Under overload the limit is met before the error level.
    assign o_lim     = i_overload && cur_r >= 3;
    assign o_trip    = cur_r >= 6;
    assign o_delay   = lvl_r >= 60;
    assign o_top     = lvl_r >= 100;
    assign o_restart = lvl_r <= 30;
endmodule

// File: test/tb_top.sv
// Self-checking bench for the switching sequencer.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QUAL = 3;
    localparam int SWC  = 2;
    localparam int LOGC = 4;
    localparam int PER  = 16;
    logic clk_sys = 1'h0;
    logic arst_n  = 1'h0;
    logic cyc_st  = 1'h0;
    logic ovl     = 1'h0;
    logic f_rise  = 1'h0;
    logic f_fall  = 1'h0;
    logic hot     = 1'h0;
    logic hot_rel = 1'h0;
    logic seen    = 1'h0;
    logic beg_seen = 1'h0;
    logic lim, trip, dly, top, rst_lv;
    logic drv_a, drv_b, chg, pull, dis, ss_dis, ss_beg, limiting;
    int   err_total  = 0;
    int   n_compared = 0;
    int   cyc_cnt    = 0;

    pofs_sequencer #(.QUAL_CYC(QUAL), .SW_CYC(SWC), .LOGIC_CYC(LOGC)) uut (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_cycle_start(cyc_st),
        .i_current_sense_input_lim(lim), .i_comp_to_sense_ratio_trip(trip),
        .i_restart_timer_node_delay_reached(dly), .i_restart_timer_node_top_reached(top),
        .i_restart_timer_node_restart_reached(rst_lv), .i_fault_rise(f_rise),
        .i_fault_above_fall(f_fall), .i_thermal_hot(hot),
        .i_thermal_above_release(hot_rel), .o_primary_drive_a(drv_a),
        .o_primary_drive_b(drv_b), .o_restart_timer_charge(chg),
        .o_restart_timer_pullup(pull), .o_restart_timer_discharge(dis),
        .o_soft_start_discharge(ss_dis), .o_soft_start_begin(ss_beg),
        .o_limiting(limiting));
    pofs_stage_model stage (
        .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_drive_on(drv_a | drv_b),
        .i_charge(chg), .i_pullup(pull), .i_discharge(dis),
        .i_overload(ovl), .o_lim(lim), .o_trip(trip), .o_delay(dly),
        .o_top(top), .o_restart(rst_lv));

    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys)
    begin
        cyc_cnt <= (cyc_cnt == PER - 1) ? 0 : cyc_cnt + 1;
        cyc_st <= (cyc_cnt == PER - 1);
    end
    // Sticky record of any drive pulse since the bench last cleared it.
    always @(posedge clk_sys)
        seen <= seen | drv_a | drv_b;
    // Sticky record of any soft-start restart pulse.
    always @(posedge clk_sys)
        beg_seen <= beg_seen | ss_beg;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: pick = limiting;
            1: pick = pull;
            2: pick = dis;
            3: pick = ss_beg;
            default: pick = ss_dis;
        endcase
    endfunction
    task automatic wait_hi(input int sel, input int max, output int n);
        n = 0;
        while (pick(sel) !== 1'h1 && n < max)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(pick(sel), 1'h1);
    endtask
    task automatic wait_cs();
        do @(negedge clk_sys); while (cyc_st !== 1'h1);
        @(negedge clk_sys);
    endtask
    task automatic stop_test();
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_normal();
        logic a0;
        wait_cs();
        a0 = drv_a;
        check(drv_a ^ drv_b, 1'h1);
        repeat (12) @(negedge clk_sys);
        check({drv_a, drv_b}, 2'h0);
        wait_cs();
        check(drv_a ^ a0, 1'h1);
        check(limiting, 1'h0);
    endtask
    task automatic t_hiccup();
        int n;
        ovl = 1'h1;
        wait_hi(0, 200, n);
        wait_cs();
        check(drv_a | drv_b, 1'h1);
        repeat (12) @(negedge clk_sys);
        check({drv_a, drv_b, chg}, 3'h1);
        wait_cs();
        check(chg, 1'h0);
        wait_hi(1, 600, n);
        check({dly, ss_dis, drv_a, drv_b}, 4'hC);
        seen = 1'h0;
        wait_hi(2, 100, n);
        check(top, 1'h1);
        wait_hi(3, 200, n);
        check({rst_lv, seen}, 2'h2);
        wait_hi(1, 800, n);
        wait_hi(3, 200, n);
        ovl = 1'h0;
        repeat (3 * PER) @(negedge clk_sys);
        check({limiting, pull, ss_dis}, 3'h0);
    endtask
    task automatic t_fault();
        int n;
        f_rise = 1'h1;
        f_fall = 1'h1;
        repeat (QUAL - 1) @(negedge clk_sys);
        f_rise = 1'h0;
        f_fall = 1'h0;
        repeat (10) @(negedge clk_sys);
        check(ss_dis, 1'h0);
        // Held well past the qualification width, as the source must.
        f_rise = 1'h1;
        f_fall = 1'h1;
        wait_hi(4, 20, n);
        seen = 1'h0;
        repeat (2 * PER) @(negedge clk_sys);
        f_rise = 1'h0;
        repeat (4) @(negedge clk_sys);
        check({seen, ss_dis}, 2'h1);
        f_fall = 1'h0;
        wait_hi(3, (SWC + 1) * PER + LOGC + 10, n);
        check(n >= LOGC + (SWC - 1) * PER, 1'h1);
        f_rise = 1'h1;
        f_fall = 1'h1;
        wait_hi(4, 20, n);
        beg_seen = 1'h0;
        f_rise = 1'h0;
        f_fall = 1'h0;
        repeat (PER) @(negedge clk_sys);
        f_rise = 1'h1;
        f_fall = 1'h1;
        repeat (2 * PER) @(negedge clk_sys);
        check({ss_dis, beg_seen}, 2'h2);
        f_rise = 1'h0;
        f_fall = 1'h0;
        wait_hi(3, (SWC + 1) * PER + LOGC + 10, n);
        check(n >= LOGC + (SWC - 1) * PER, 1'h1);
    endtask
    task automatic t_thermal();
        int n;
        hot = 1'h1;
        hot_rel = 1'h1;
        wait_hi(4, 20, n);
        seen = 1'h0;
        hot = 1'h0;
        repeat (2 * PER) @(negedge clk_sys);
        check({seen, ss_dis}, 2'h1);
        hot_rel = 1'h0;
        wait_hi(3, 40, n);
    endtask

    initial
    begin
        repeat (5) @(negedge clk_sys);
        arst_n = 1'h1;
        repeat (4) @(negedge clk_sys);
        t_normal();
        t_hiccup();
        t_fault();
        t_thermal();
        arst_n = 1'h0;
        @(negedge clk_sys);
        check({drv_a, drv_b, chg, pull, dis, ss_dis, ss_beg, limiting},
              8'h00);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
endmodule
